// [logic/hst_tia_config_regs.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hst_cfg.svh"
module hst_tia_config_regs
	import hst_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output hst_ctrl_t analogCtrl
);
	////////////////////////////////////////////////////////////////////
	hst_state_t state_q;
	hst_state_t state_d;
	logic setupPhase;
	logic hitGain;
	logic hitSense;
	logic hitAmp;
	logic [31:0] wMask;

	assign setupPhase = psel && !penable;
	assign hitGain = paddr == `HST_GAIN_ADDR;
	assign hitSense = paddr == `HST_SENSE_ADDR;
	assign hitAmp = paddr == `HST_AMP_ADDR;

	////////////////////////////////////////////////////////////////////
	// No wait state: answer prepared in setup, presented in the first access cycle
	always_comb
	begin
		state_d = state_q;
		state_d.ready = 1'b0;
		state_d.slverr = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			wMask[i*8 +: 8] = {8{pstrb[i]}};
		end
		if (setupPhase)
		begin
			state_d.ready = 1'b1;
			state_d.slverr = !(hitGain || hitSense || hitAmp);
			state_d.rdata = 32'h00000000;
			if (!pwrite)
			begin
				// Reserved upper bits stay zero on read
				if (hitGain)
					state_d.rdata = {19'h00000, state_q.gain};
				else if (hitSense)
					state_d.rdata = {24'h000000, state_q.sense};
				else if (hitAmp)
					state_d.rdata = {30'h00000000, state_q.amp};
			end
		end
		if (psel && penable && state_q.ready && pwrite)
		begin
			// Only implemented bits stored; reserved writes dropped
			if (hitGain)
				state_d.gain = (state_q.gain & ~wMask[12:0]) | (pwdata[12:0] & wMask[12:0]);
			if (hitSense)
				state_d.sense = (state_q.sense & ~wMask[7:0]) | (pwdata[7:0] & wMask[7:0]);
			if (hitAmp)
				state_d.amp = (state_q.amp & ~wMask[1:0]) | (pwdata[1:0] & wMask[1:0]);
		end
		// Decode uses next values so controls track registers with no extra lag
		state_d.ctrl.gainOneHot = 8'h00;
		for (int k = 0; k < 8; k++)
		begin
			state_d.ctrl.gainOneHot[k] = state_d.gain.resSel == 4'(k);
		end
		state_d.ctrl.gainOpen = state_d.gain.resSel >= `HST_RES_OPEN_MIN;
		state_d.ctrl.diodeOn = state_d.gain.diodeOn;
		// Pattern 0 is the 1 pF base; bits 0..3 add 2..16 pF; bit 4 adds 2 pF
		state_d.ctrl.capOneHot = {state_d.gain.capSel[9:5], state_d.gain.capSel == 8'h00};
		state_d.ctrl.senseCode = state_d.sense;
		state_d.ctrl.senseShort = state_d.sense == `HST_SHORT_CODE;
		state_d.ctrl.senseOff = state_d.sense == `HST_SENSE_RST;
		// Reserved codes select neither source
		state_d.ctrl.posBias = state_d.amp == HST_BIAS;
		state_d.ctrl.posDacZero = state_d.amp == HST_DACZERO;
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= '0;
			state_q.gain <= `HST_GAIN_RST;
			state_q.sense <= `HST_SENSE_RST;
			state_q.amp <= `HST_AMP_RST;
			state_q.ctrl.gainOpen <= 1'b1;
			state_q.ctrl.capOneHot <= 6'h01;
			state_q.ctrl.senseCode <= `HST_SENSE_RST;
			state_q.ctrl.senseOff <= 1'b1;
			state_q.ctrl.posBias <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign prdata = state_q.rdata;
	assign pready = state_q.ready;
	assign pslverr = state_q.slverr;
	assign analogCtrl = state_q.ctrl;

	////////////////////////////////////////////////////////////////////
	gain_write_a: assert property (@(posedge core_clk) disable iff (rst)
		psel && penable && pready && pwrite && hitGain && pstrb[0]
		|=> state_q.gain.resSel == $past(pwdata[3:0]))
		else $error("gain code not stored");
	gain_open_a: assert property (@(posedge core_clk) disable iff (rst)
		analogCtrl.gainOpen == (state_q.gain.resSel[3]) && $countones(analogCtrl.gainOneHot)
		== (state_q.gain.resSel[3] ? 0 : 1))
		else $error("gain decode wrong");
	diode_track_a: assert property (@(posedge core_clk) disable iff (rst)
		analogCtrl.diodeOn == state_q.gain.diodeOn)
		else $error("diode switch mismatch");
	cap_base_a: assert property (@(posedge core_clk) disable iff (rst)
		analogCtrl.capOneHot[0] == (state_q.gain.capSel == 8'h00))
		else $error("cap base wrong");
	posin_sel_a: assert property (@(posedge core_clk) disable iff (rst)
		!(analogCtrl.posBias && analogCtrl.posDacZero)
		&& analogCtrl.posBias == (state_q.amp == 2'h0))
		else $error("positive input wrong");
	reset_val_a: assert property (@(posedge core_clk)
		$fell(rst) |-> state_q.gain == 13'h000F && state_q.sense == 8'hFF
		&& state_q.amp == 2'h0)
		else $error("reset values wrong");
	short_code_a: assert property (@(posedge core_clk) disable iff (rst)
		analogCtrl.senseShort == (state_q.sense == 8'h97))
		else $error("sense short wrong");
	rsv_read_a: assert property (@(posedge core_clk) disable iff (rst)
		pready && hitSense |-> prdata[31:8] == 24'h000000)
		else $error("reserved bits nonzero");
	apb_wait_a: assert property (@(posedge core_clk) disable iff (rst)
		psel && !penable |=> pready ##1 !pready)
		else $error("apb timing wrong");

	////////////////////////////////////////////////////////////////////
	// Gain register decode: resistor, diode and capacitor
	gain_onehot_a: assert property (@(posedge core_clk) disable iff (rst)
		!state_q.gain.resSel[3] |-> analogCtrl.gainOneHot == (8'h01 << state_q.gain.resSel[2:0]))
		else $error("gain one-hot wrong");
	gain_none_a: assert property (@(posedge core_clk) disable iff (rst)
		state_q.gain.resSel[3] |-> analogCtrl.gainOneHot == 8'h00 && analogCtrl.gainOpen)
		else $error("open code selects resistor");
	diode_write_a: assert property (@(posedge core_clk) disable iff (rst)
		psel && penable && pready && pwrite && hitGain && pstrb[0]
		|=> analogCtrl.diodeOn == $past(pwdata[4]))
		else $error("diode write lost");
	cap_write_a: assert property (@(posedge core_clk) disable iff (rst)
		psel && penable && pready && pwrite && hitGain && pstrb[0] && pstrb[1]
		|=> state_q.gain.capSel == $past(pwdata[12:5]))
		else $error("cap write lost");
	cap_bits_a: assert property (@(posedge core_clk) disable iff (rst)
		analogCtrl.capOneHot[5:1] == state_q.gain.capSel[9:5])
		else $error("cap decode wrong");
	gain_mask_a: assert property (@(posedge core_clk) disable iff (rst)
		psel && penable && pready && pwrite && hitGain && !pstrb[0]
		|=> state_q.gain[7:0] == $past(state_q.gain[7:0]))
		else $error("masked byte written");

	////////////////////////////////////////////////////////////////////
	// Sense pin path
	sense_write_a: assert property (@(posedge core_clk) disable iff (rst)
		psel && penable && pready && pwrite && hitSense && pstrb[0]
		|=> state_q.sense == $past(pwdata[7:0]))
		else $error("sense write lost");
	sense_code_a: assert property (@(posedge core_clk) disable iff (rst)
		analogCtrl.senseCode == state_q.sense)
		else $error("sense code mismatch");
	sense_off_a: assert property (@(posedge core_clk) disable iff (rst)
		analogCtrl.senseOff == (state_q.sense == 8'hFF))
		else $error("sense off wrong");
	short_only_a: assert property (@(posedge core_clk) disable iff (rst)
		analogCtrl.senseShort |-> !analogCtrl.senseOff && analogCtrl.senseCode == 8'h97)
		else $error("short with wrong code");

	////////////////////////////////////////////////////////////////////
	// Amplifier positive input
	amp_write_a: assert property (@(posedge core_clk) disable iff (rst)
		psel && penable && pready && pwrite && hitAmp && pstrb[0]
		|=> state_q.amp == $past(pwdata[1:0]))
		else $error("amp write lost");
	dac_zero_a: assert property (@(posedge core_clk) disable iff (rst)
		analogCtrl.posDacZero == (state_q.amp == 2'h1))
		else $error("dac zero select wrong");
	rsv_code_a: assert property (@(posedge core_clk) disable iff (rst)
		state_q.amp[1] |-> !analogCtrl.posBias && !analogCtrl.posDacZero)
		else $error("reserved code selects input");

	////////////////////////////////////////////////////////////////////
	// Read path and reserved space
	gain_read_a: assert property (@(posedge core_clk) disable iff (rst)
		psel && penable && pready && !pwrite && hitGain |-> prdata == {19'h00000, state_q.gain})
		else $error("gain read wrong");
	sense_read_a: assert property (@(posedge core_clk) disable iff (rst)
		psel && penable && pready && !pwrite && hitSense |-> prdata == {24'h000000, state_q.sense})
		else $error("sense read wrong");
	amp_read_a: assert property (@(posedge core_clk) disable iff (rst)
		psel && penable && pready && !pwrite && hitAmp |-> prdata == {30'h00000000, state_q.amp})
		else $error("amp read wrong");
	gain_rsv_a: assert property (@(posedge core_clk) disable iff (rst)
		pready && hitGain |-> prdata[31:13] == 19'h00000)
		else $error("gain reserved nonzero");
	amp_rsv_a: assert property (@(posedge core_clk) disable iff (rst)
		pready && hitAmp |-> prdata[31:2] == 30'h00000000)
		else $error("amp reserved nonzero");
	unmapped_err_a: assert property (@(posedge core_clk) disable iff (rst)
		pready && !(hitGain || hitSense || hitAmp) |-> pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");
	err_pair_a: assert property (@(posedge core_clk) disable iff (rst)
		pslverr |-> pready)
		else $error("error without ready");
	unmapped_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		psel && penable && pready && pwrite && !(hitGain || hitSense || hitAmp)
		|=> $stable(state_q.gain) && $stable(state_q.sense) && $stable(state_q.amp))
		else $error("unmapped write changed state");
	read_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		psel && penable && pready && !pwrite
		|=> $stable(state_q.gain) && $stable(state_q.sense) && $stable(state_q.amp))
		else $error("read changed state");
	idle_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		!psel |=> $stable(state_q.gain) && $stable(state_q.sense) && $stable(state_q.amp))
		else $error("idle bus changed state");
	idle_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
		!psel |=> !pready && !pslverr)
		else $error("answer without request");
endmodule
`default_nettype wire

// [pkg/hst_cfg.svh]
`ifndef HST_CFG_SVH
`define HST_CFG_SVH
`define HST_GAIN_ADDR 32'h000020F0
`define HST_SENSE_ADDR 32'h000020F8
`define HST_AMP_ADDR 32'h000020FC
`define HST_GAIN_RST 13'h000F
`define HST_SENSE_RST 8'hFF
`define HST_AMP_RST 2'h0
`define HST_GAIN_W 13
`define HST_SENSE_W 8
`define HST_AMP_W 2
`define HST_RES_LSB 0
`define HST_DIODE_BIT 4
`define HST_CAP_LSB 5
`define HST_SHORT_CODE 8'h97
`define HST_RES_OPEN_MIN 4'h8
`endif

// [pkg/hst_pkg.sv]
package hst_pkg;
	typedef struct packed {
		logic [12:5] capSel;
		logic diodeOn;
		logic [3:0] resSel;
	} hst_gain_t;
	typedef enum logic [1:0] {HST_BIAS, HST_DACZERO, HST_RSV2, HST_RSV3} hst_posin_t;
	typedef struct packed {
		logic [7:0] gainOneHot;
		logic gainOpen;
		logic diodeOn;
		logic [5:0] capOneHot;
		logic [7:0] senseCode;
		logic senseShort;
		logic senseOff;
		logic posBias;
		logic posDacZero;
	} hst_ctrl_t;
	typedef struct packed {
		hst_gain_t gain;
		logic [7:0] sense;
		logic [1:0] amp;
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		hst_ctrl_t ctrl;
	} hst_state_t;
endpackage

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "hst_cfg.svh"
module testbench
	import hst_pkg::*;
;
logic core_clk = 0;
logic rst = 1;
logic psel = 0;
logic penable = 0;
logic pwrite = 0;
logic [31:0] paddr = 0;
logic [31:0] pwdata = 0;
logic [31:0] prdata;
logic [31:0] rdv;
logic pready;
logic pslverr;
logic errv;
hst_ctrl_t analogCtrl;
int fail_count = 0;
int check_count = 0;
always #2.5 core_clk = ~core_clk;
hst_tia_config_regs dut_u(.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .analogCtrl(analogCtrl));
////////////////////////////////
task complete_run;
	$display("checks %0d fails %0d", check_count, fail_count);
	if (fail_count == 0 && check_count > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask
task chk(input logic [31:0] g, input logic [31:0] e);
	check_count++;
	if (g !== e)
	begin
		fail_count++;
		$display("Error %0t got %h exp %h", $time, g, e);
	end
endtask
// Bounded wait: a slave that never answers ends the run
task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
	int n;
	n = 0;
	@(posedge core_clk);
	psel <= 1'b1;
	penable <= 1'b0;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge core_clk);
	penable <= 1'b1;
	// Registered answer is looked at mid-cycle, where it stands settled
	do
	begin
		@(negedge core_clk);
		n++;
	end
	while (pready !== 1'b1 && n < 9);
	if (n == 9)
	begin
		fail_count++;
		complete_run;
	end
	rdv = prdata;
	errv = pslverr;
	// Request held up to the edge that samples pready high
	@(posedge core_clk);
	psel <= 1'b0;
	penable <= 1'b0;
	@(negedge core_clk);
endtask
////////////////////////////////
initial
begin
	repeat (5) @(posedge core_clk);
	rst <= 1'b0;
	apb(0, `HST_GAIN_ADDR, 0);
	chk(rdv, 32'h0000000F);
	chk(32'(analogCtrl.gainOpen), 32'h1);
	apb(0, `HST_SENSE_ADDR, 0);
	chk(rdv, 32'h000000FF);
	apb(0, `HST_AMP_ADDR, 0);
	chk(rdv, 32'h00000000);
	chk(32'(analogCtrl.posBias), 32'h1);
	$display("reset test done");
	for (int i = 0; i < 8; i++)
	begin
		apb(1, `HST_GAIN_ADDR, i);
		chk(32'(analogCtrl.gainOneHot), 32'h1 << i);
	end
	apb(1, `HST_GAIN_ADDR, 32'h18);
	chk(32'({analogCtrl.gainOneHot, analogCtrl.gainOpen, analogCtrl.diodeOn}), 32'h3);
	for (int k = 0; k < 5; k++)
	begin
		apb(1, `HST_GAIN_ADDR, 32'h20 << k);
		chk(32'(analogCtrl.capOneHot), 32'h2 << k);
	end
	apb(1, `HST_GAIN_ADDR, 32'hFFFFFFFF);
	apb(0, `HST_GAIN_ADDR, 0);
	chk(rdv, 32'h00001FFF);
	$display("gain test done");
	apb(1, `HST_SENSE_ADDR, 32'hFFFFFF97);
	chk(32'({analogCtrl.senseShort, analogCtrl.senseOff, analogCtrl.senseCode}), 32'h297);
	chk(32'({analogCtrl.senseShort, analogCtrl.gainOpen}), 32'h3);
	apb(0, `HST_SENSE_ADDR, 0);
	chk(rdv, 32'h00000097);
	apb(1, `HST_AMP_ADDR, 32'hFFFFFFFD);
	chk(32'({analogCtrl.posBias, analogCtrl.posDacZero}), 32'h1);
	apb(0, `HST_AMP_ADDR, 0);
	chk(rdv, 32'h00000001);
	apb(0, 32'h000020F4, 0);
	chk(32'(errv), 32'h1);
	chk(rdv, 32'h00000000);
	$display("sense amp test done");
	complete_run;
end
endmodule
`default_nettype wire
